//--- common/drive_input_pkg.sv
// Functional notes
// - analog inputs scaled by setting over 1000
// - pre-ramp speed reference scaled by its setting/1000
// - three analog outputs scaled by setting/1000
// - encoder scale is 750e6 over lines*rpm
// - selector 0 analog, 1 encoder reference
// - selector picks voltage or 20mA speed input
// - two bits pick the current loop range
// - 4mA offset ranges trip below 3.5mA
// - invert bit reverses inputs c and d
// - inversion leaves c and d monitors unchanged
// - start only with permit; report permit state
// - permit loss forces pre-ramp reference zero
// - permit loss stops motor unless ramp hold
// - logic input states reported as read bits
// - inch/run commands only when normal logic on
// - each logic input freely routable by config
// - run inputs latch reference-on flag
// - disable bit 0 fixed functions, 1 user
package drive_input_pkg;
  localparam int VAL_W = 11;                 // signed signal width
  localparam int SCALE_W = 11;               // scaling setting width
  localparam int DATA_W = 16;                // parameter data width
  localparam int ADDR_W = 5;                 // parameter index width
  localparam int MA_W = 9;                   // loop current, 0.1mA units
  localparam int NUM_SCALERS = 8;            // scaled channels
  localparam int NUM_LOGIC = 5;              // programmable logic inputs
  localparam int DEST_W = 3;                 // routing selector width
  localparam int NUM_DEST = 8;               // routing destinations
  localparam int CNT_W = 16;                 // encoder pulse counter
  localparam int CLK_MHZ = 250;              // core clock rate
  // scaling arithmetic
  localparam logic [SCALE_W-1:0] SCALE_DEFAULT = 11'h3E8;
  localparam logic [SCALE_W-1:0] SCALE_MAX = 11'h7CF;
  localparam int SCALE_DIV = 1000;
  localparam int VAL_LIMIT = 1000;
  // encoder reference
  localparam int ENC_NUMERATOR = 750000000;
  localparam int ENC_PPR = 1024;
  localparam int ENC_MAX_RPM = 1750;
  localparam logic [SCALE_W-1:0] ENC_SCALE_DEFAULT =
    SCALE_W'(ENC_NUMERATOR / (ENC_PPR * ENC_MAX_RPM));
  localparam int ENC_WINDOW_MS = 80;         // pulse gate time
  localparam int ENC_WINDOW_CYC = ENC_WINDOW_MS * CLK_MHZ * 1000;
  // current loop, in 0.1mA
  localparam int LOOP_FULL = 200;
  localparam int LOOP_OFFSET = 40;
  localparam int LOOP_TRIP = 35;
  // parameter indices
  localparam logic [ADDR_W-1:0] P_IN_A_SCALE = 5'h00;
  localparam logic [ADDR_W-1:0] P_OUT_C_SCALE = 5'h07;
  localparam logic [ADDR_W-1:0] P_ENC_SCALE = 5'h08;
  localparam logic [ADDR_W-1:0] P_REF_SOURCE = 5'h09;
  localparam logic [ADDR_W-1:0] P_CUR_SELECT = 5'h0A;
  localparam logic [ADDR_W-1:0] P_LOOP_DIR = 5'h0B;
  localparam logic [ADDR_W-1:0] P_LOOP_OFFSET = 5'h0C;
  localparam logic [ADDR_W-1:0] P_INVERT_CD = 5'h0D;
  localparam logic [ADDR_W-1:0] P_NORMAL_OFF = 5'h0E;
  localparam logic [ADDR_W-1:0] P_LOGIC_ROUTE = 5'h0F;
  localparam logic [ADDR_W-1:0] P_SOFT_REF_ON = 5'h10;
  localparam logic [ADDR_W-1:0] P_STATUS = 5'h11;
  // channel numbers of the scaler bank
  localparam int CH_IN_C = 2;
  localparam int CH_IN_D = 3;
  localparam int CH_SPEED = 4;
  localparam int CH_OUT_A = 5;
  // logic input bit positions
  localparam int L_INCH_REV = 0;
  localparam int L_INCH_FWD = 1;
  localparam int L_RUN_REV = 2;
  localparam int L_RUN_FWD = 3;
  // reset values of bit settings
  localparam logic LOOP_OFFSET_RESET = 1'b1;
  localparam logic BIT_RESET = 1'b0;
endpackage

//--- hw/sync_two_flop.sv
`timescale 1ns/10ps
// two-flop synchroniser for terminal inputs
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta; // first stage, read only by o_sync

  // both stages clear on reset, then follow the pin
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule

//--- hw/value_scaler.sv
`timescale 1ns/10ps
// multiplies a signed value by setting/1000, one cycle latency
module value_scaler
  import drive_input_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic signed [drive_input_pkg::VAL_W-1:0] i_value,
  input wire logic [drive_input_pkg::SCALE_W-1:0] i_scale,
  output logic signed [drive_input_pkg::VAL_W-1:0] o_value
);
  logic signed [31:0] product; // full product
  logic signed [31:0] quotient; // truncated toward zero

  // product and division, fraction dropped
  always_comb begin
    product = 32'(i_value) * $signed({21'h0, i_scale});
    quotient = product / SCALE_DIV;
  end

  // saturate to the signal range and register
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_value <= '0;
    end else if (quotient > VAL_LIMIT) begin
      o_value <= VAL_W'(VAL_LIMIT);
    end else if (quotient < -VAL_LIMIT) begin
      o_value <= VAL_W'(-VAL_LIMIT);
    end else begin
      o_value <= VAL_W'(quotient);
    end
  end
endmodule

//--- hw/drive_input_scaling_logic.sv
`timescale 1ns/10ps
// input conditioning: scaling, reference select, logic inputs
module drive_input_scaling_logic #(
  parameter int ENC_WINDOW = drive_input_pkg::ENC_WINDOW_CYC
) (
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  // parameter access port
  input wire logic i_PARAM_WE,
  input wire logic [drive_input_pkg::ADDR_W-1:0] i_PARAM_ADDR,
  input wire logic [drive_input_pkg::DATA_W-1:0] i_PARAM_WDATA,
  output logic [drive_input_pkg::DATA_W-1:0] o_PARAM_RDATA,
  // converted analog samples, same clock
  input wire logic signed [drive_input_pkg::VAL_W-1:0] i_ANALOG_IN_A,
  input wire logic signed [drive_input_pkg::VAL_W-1:0] i_ANALOG_IN_B,
  input wire logic signed [drive_input_pkg::VAL_W-1:0] i_ANALOG_IN_C,
  input wire logic signed [drive_input_pkg::VAL_W-1:0] i_ANALOG_IN_D,
  input wire logic signed [drive_input_pkg::VAL_W-1:0] i_SPEED_VOLT,
  input wire logic [drive_input_pkg::MA_W-1:0] i_SPEED_CURRENT,
  input wire logic signed [drive_input_pkg::VAL_W-1:0] i_AOUT_SRC_A,
  input wire logic signed [drive_input_pkg::VAL_W-1:0] i_AOUT_SRC_B,
  input wire logic signed [drive_input_pkg::VAL_W-1:0] i_AOUT_SRC_C,
  // terminal pins
  input wire logic i_ENCODER_SOCKET,
  input wire logic i_START_PERMIT_TERMINAL,
  input wire logic [drive_input_pkg::NUM_LOGIC-1:0] i_LOGIC_IN,
  // same-clock controls
  input wire logic i_RAMP_HOLD,
  input wire logic i_TRIP_CLEAR,
  // scaled results, raw monitors and raw speed reference
  output logic signed [drive_input_pkg::VAL_W-1:0] o_ANALOG_IN_A,
  output logic signed [drive_input_pkg::VAL_W-1:0] o_ANALOG_IN_B,
  output logic signed [drive_input_pkg::VAL_W-1:0] o_ANALOG_IN_C,
  output logic signed [drive_input_pkg::VAL_W-1:0] o_ANALOG_IN_D,
  output logic signed [drive_input_pkg::VAL_W-1:0] o_MON_IN_C,
  output logic signed [drive_input_pkg::VAL_W-1:0] o_MON_IN_D,
  output logic signed [drive_input_pkg::VAL_W-1:0] o_SPEED_REF_IN,
  output logic signed [drive_input_pkg::VAL_W-1:0] o_PRE_RAMP_REF,
  output logic signed [drive_input_pkg::VAL_W-1:0] o_ANALOG_OUT_A,
  output logic signed [drive_input_pkg::VAL_W-1:0] o_ANALOG_OUT_B,
  output logic signed [drive_input_pkg::VAL_W-1:0] o_ANALOG_OUT_C,
  // status and commands
  output logic o_LOOP_OPEN_TRIP,
  output logic o_START_PERMIT,
  output logic [drive_input_pkg::NUM_LOGIC-1:0] o_LOGIC_STATE,
  output logic o_INCH_REV,
  output logic o_INCH_FWD,
  output logic o_RUN_REV,
  output logic o_RUN_FWD,
  output logic o_REF_ON,
  output logic o_DRIVE_STOP,
  output logic [drive_input_pkg::NUM_DEST-1:0] o_USER_DEST
);
  import drive_input_pkg::*;

  // scaling settings, one per scaler channel
  logic [SCALE_W-1:0] scale [NUM_SCALERS];
  logic [SCALE_W-1:0] enc_scale; // encoder reference factor
  logic ref_source; // 0 analog, 1 encoder
  logic cur_select; // 0 voltage, 1 current loop
  logic loop_dir; // reversed loop range
  logic loop_offset; // 4mA offset range
  logic invert_cd; // invert inputs c and d
  logic normal_off; // 1 disables fixed logic functions
  logic [NUM_LOGIC*DEST_W-1:0] logic_route; // per-input destination
  logic soft_ref_on; // software reference-on request
  logic [NUM_DEST-1:0] next_user_dest; // routed input levels

  // synchronised pins
  logic enc_s;
  logic permit_s;
  logic [NUM_LOGIC-1:0] logic_s;

  // scaler bank wiring
  logic signed [VAL_W-1:0] sc_in [NUM_SCALERS];
  logic signed [VAL_W-1:0] sc_out [NUM_SCALERS];

  // encoder measurement
  logic enc_prev; // previous synchronised level
  logic [CNT_W-1:0] enc_count; // pulses in current window
  logic [31:0] win_count; // gate timer
  logic signed [VAL_W-1:0] enc_ref; // last window result
  logic [31:0] enc_product; // count times factor

  // current loop conversion
  logic signed [VAL_W-1:0] loop_value;
  logic signed [VAL_W-1:0] speed_sel; // selected raw reference
  logic loop_low; // loop current below threshold

  // clamped scaling write data
  logic [SCALE_W-1:0] wr_scale;

  // pin synchronisers
  sync_two_flop #(.WIDTH(2 + NUM_LOGIC)) u_pin_sync (
    .i_clk(I_CLOCK),
    .i_resetn(I_RESETN),
    .i_async({i_ENCODER_SOCKET, i_START_PERMIT_TERMINAL, i_LOGIC_IN}),
    .o_sync({enc_s, permit_s, logic_s})
  );

  // scaler channel writes above the range clamp to the maximum; encoder factor writes are truncated
  always_comb begin
    if (i_PARAM_WDATA > DATA_W'(SCALE_MAX)) begin
      wr_scale = SCALE_MAX;
    end else begin
      wr_scale = i_PARAM_WDATA[SCALE_W-1:0];
    end
  end

  // scaling settings storage
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      for (int k = 0; k < NUM_SCALERS; k++) begin
        scale[k] <= SCALE_DEFAULT;
      end
      enc_scale <= ENC_SCALE_DEFAULT;
    end else if (i_PARAM_WE) begin
      for (int k = 0; k < NUM_SCALERS; k++) begin
        if (i_PARAM_ADDR == ADDR_W'(k)) begin
          scale[k] <= wr_scale;
        end
      end
      if (i_PARAM_ADDR == P_ENC_SCALE) begin
        enc_scale <= i_PARAM_WDATA[SCALE_W-1:0];
      end
    end
  end

  // bit settings storage
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      ref_source <= BIT_RESET;
      cur_select <= BIT_RESET;
      loop_dir <= BIT_RESET;
      loop_offset <= LOOP_OFFSET_RESET;
      invert_cd <= BIT_RESET;
      normal_off <= BIT_RESET;
      logic_route <= '0;
      soft_ref_on <= BIT_RESET;
    end else if (i_PARAM_WE) begin
      case (i_PARAM_ADDR)
        P_REF_SOURCE: ref_source <= i_PARAM_WDATA[0];
        P_CUR_SELECT: cur_select <= i_PARAM_WDATA[0];
        P_LOOP_DIR: loop_dir <= i_PARAM_WDATA[0];
        P_LOOP_OFFSET: loop_offset <= i_PARAM_WDATA[0];
        P_INVERT_CD: invert_cd <= i_PARAM_WDATA[0];
        P_NORMAL_OFF: normal_off <= i_PARAM_WDATA[0];
        P_LOGIC_ROUTE: begin
          logic_route <= i_PARAM_WDATA[NUM_LOGIC*DEST_W-1:0];
        end
        P_SOFT_REF_ON: soft_ref_on <= i_PARAM_WDATA[0];
        default: begin
        end
      endcase
    end
  end

  // registered read-back, one cycle after the index
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      o_PARAM_RDATA <= '0;
    end else if (i_PARAM_ADDR <= P_OUT_C_SCALE) begin
      o_PARAM_RDATA <= DATA_W'(scale[i_PARAM_ADDR[2:0]]);
    end else begin
      case (i_PARAM_ADDR)
        P_ENC_SCALE: o_PARAM_RDATA <= DATA_W'(enc_scale);
        P_REF_SOURCE: o_PARAM_RDATA <= DATA_W'(ref_source);
        P_CUR_SELECT: o_PARAM_RDATA <= DATA_W'(cur_select);
        P_LOOP_DIR: o_PARAM_RDATA <= DATA_W'(loop_dir);
        P_LOOP_OFFSET: o_PARAM_RDATA <= DATA_W'(loop_offset);
        P_INVERT_CD: o_PARAM_RDATA <= DATA_W'(invert_cd);
        P_NORMAL_OFF: o_PARAM_RDATA <= DATA_W'(normal_off);
        P_LOGIC_ROUTE: o_PARAM_RDATA <= DATA_W'(logic_route);
        P_SOFT_REF_ON: o_PARAM_RDATA <= DATA_W'(soft_ref_on);
        // status: ref-on, trip, permit, logic inputs
        P_STATUS: begin
          o_PARAM_RDATA <= DATA_W'({o_REF_ON, o_LOOP_OPEN_TRIP,
                                    permit_s, logic_s});
        end
        default: o_PARAM_RDATA <= '0;
      endcase
    end
  end

  // current loop range mapping to the signal range
  always_comb begin
    int cur;
    int v;
    v = 0;
    cur = int'(i_SPEED_CURRENT);
    if (loop_offset) begin
      v = ((cur - LOOP_OFFSET) * VAL_LIMIT) / (LOOP_FULL - LOOP_OFFSET);
    end else begin
      v = (cur * VAL_LIMIT) / LOOP_FULL;
    end
    if (v < 0) begin
      v = 0;
    end else if (v > VAL_LIMIT) begin
      v = VAL_LIMIT;
    end
    if (loop_dir) begin
      v = VAL_LIMIT - v;
    end
    loop_value = VAL_W'(v);
    loop_low = cur < LOOP_TRIP;
  end

  // analog speed input: voltage or current, then source select
  always_comb begin
    if (ref_source) begin
      speed_sel = enc_ref;
    end else if (cur_select) begin
      speed_sel = loop_value;
    end else begin
      speed_sel = i_SPEED_VOLT;
    end
  end

  // open loop trip, set wins over clear
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      o_LOOP_OPEN_TRIP <= 1'b0;
    end else if (cur_select && loop_offset && loop_low) begin
      o_LOOP_OPEN_TRIP <= 1'b1;
    end else if (i_TRIP_CLEAR) begin
      o_LOOP_OPEN_TRIP <= 1'b0;
    end
  end

  // encoder pulse counting over a fixed gate window
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      enc_prev <= 1'b0;
      enc_count <= '0;
      win_count <= '0;
      enc_ref <= '0;
    end else begin
      enc_prev <= enc_s;
      if (win_count >= 32'(ENC_WINDOW - 1)) begin
        win_count <= '0;
        // an edge on the closing cycle opens the next window count
        enc_count <= (enc_s && !enc_prev) ? CNT_W'(1) : '0;
        // factor*count/1000 reaches full scale at top speed
        if (enc_product / SCALE_DIV > VAL_LIMIT) begin
          enc_ref <= VAL_W'(VAL_LIMIT);
        end else begin
          enc_ref <= VAL_W'(enc_product / SCALE_DIV);
        end
      end else begin
        win_count <= win_count + 32'h1;
        if (enc_s && !enc_prev && enc_count != '1) begin
          enc_count <= enc_count + 16'h1;
        end
      end
    end
  end
  assign enc_product = 32'(enc_count) * 32'(enc_scale);

  // scaler inputs; c and d inverted ahead of scaling only
  always_comb begin
    sc_in[0] = i_ANALOG_IN_A;
    sc_in[1] = i_ANALOG_IN_B;
    sc_in[CH_IN_C] = invert_cd ? -i_ANALOG_IN_C : i_ANALOG_IN_C;
    sc_in[CH_IN_D] = invert_cd ? -i_ANALOG_IN_D : i_ANALOG_IN_D;
    sc_in[CH_SPEED] = speed_sel;
    sc_in[CH_OUT_A] = i_AOUT_SRC_A;
    sc_in[CH_OUT_A+1] = i_AOUT_SRC_B;
    sc_in[CH_OUT_A+2] = i_AOUT_SRC_C;
  end

  // scaler bank, one per channel
  for (genvar g = 0; g < NUM_SCALERS; g++) begin : g_scale
    value_scaler u_scaler (
      .i_clk(I_CLOCK),
      .i_resetn(I_RESETN),
      .i_value(sc_in[g]),
      .i_scale(scale[g]),
      .o_value(sc_out[g])
    );
  end

  // scaled outputs and monitors
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      o_ANALOG_IN_A <= '0;
      o_ANALOG_IN_B <= '0;
      o_ANALOG_IN_C <= '0;
      o_ANALOG_IN_D <= '0;
      o_MON_IN_C <= '0;
      o_MON_IN_D <= '0;
      o_SPEED_REF_IN <= '0;
      o_ANALOG_OUT_A <= '0;
      o_ANALOG_OUT_B <= '0;
      o_ANALOG_OUT_C <= '0;
    end else begin
      o_ANALOG_IN_A <= sc_out[0];
      o_ANALOG_IN_B <= sc_out[1];
      o_ANALOG_IN_C <= sc_out[CH_IN_C];
      o_ANALOG_IN_D <= sc_out[CH_IN_D];
      o_MON_IN_C <= i_ANALOG_IN_C;
      o_MON_IN_D <= i_ANALOG_IN_D;
      o_SPEED_REF_IN <= speed_sel;
      o_ANALOG_OUT_A <= sc_out[CH_OUT_A];
      o_ANALOG_OUT_B <= sc_out[CH_OUT_A+1];
      o_ANALOG_OUT_C <= sc_out[CH_OUT_A+2];
    end
  end

  // pre-ramp reference forced to zero without permit
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      o_PRE_RAMP_REF <= '0;
    end else if (!permit_s) begin
      o_PRE_RAMP_REF <= '0;
    end else begin
      o_PRE_RAMP_REF <= sc_out[CH_SPEED];
    end
  end

  // permit, input states and stop
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      o_START_PERMIT <= 1'b0;
      o_LOGIC_STATE <= '0;
      o_DRIVE_STOP <= 1'b1;
    end else begin
      o_START_PERMIT <= permit_s;
      o_LOGIC_STATE <= logic_s;
      o_DRIVE_STOP <= !permit_s && !i_RAMP_HOLD;
    end
  end

  // fixed inch and run commands under normal logic
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      o_INCH_REV <= 1'b0;
      o_INCH_FWD <= 1'b0;
      o_RUN_REV <= 1'b0;
      o_RUN_FWD <= 1'b0;
    end else if (normal_off || !permit_s) begin
      o_INCH_REV <= 1'b0;
      o_INCH_FWD <= 1'b0;
      o_RUN_REV <= 1'b0;
      o_RUN_FWD <= 1'b0;
    end else begin
      o_INCH_REV <= logic_s[L_INCH_REV];
      o_INCH_FWD <= logic_s[L_INCH_FWD];
      // run direction latches until the other run input
      if (logic_s[L_RUN_REV]) begin
        o_RUN_REV <= 1'b1;
        o_RUN_FWD <= 1'b0;
      end else if (logic_s[L_RUN_FWD]) begin
        o_RUN_REV <= 1'b0;
        o_RUN_FWD <= 1'b1;
      end
    end
  end

  // reference-on: latched by run inputs, software in user mode
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      o_REF_ON <= 1'b0;
    end else if (!permit_s) begin
      o_REF_ON <= 1'b0;
    end else if (normal_off) begin
      o_REF_ON <= soft_ref_on;
    end else if (logic_s[L_RUN_REV] || logic_s[L_RUN_FWD]) begin
      o_REF_ON <= 1'b1;
    end
  end

  // user routing: each input drives its chosen destination
  always_comb begin
    next_user_dest = '0;
    for (int k = 0; k < NUM_LOGIC; k++) begin
      if (logic_s[k]) begin
        next_user_dest[logic_route[k*DEST_W +: DEST_W]] = 1'b1;
      end
    end
    next_user_dest[0] = 1'b0; // destination 0 means unrouted
  end

  // routed destinations registered
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      o_USER_DEST <= '0;
    end else begin
      o_USER_DEST <= next_user_dest;
    end
  end

  // assertions
  sequence s_permit_drop;
    permit_s ##1 !permit_s;
  endsequence

  sequence s_run_press;
    !normal_off && permit_s && (logic_s[L_RUN_REV] || logic_s[L_RUN_FWD]);
  endsequence

  a_ramp_zero_drop: assert property (@(posedge I_CLOCK)
    disable iff (!I_RESETN) s_permit_drop |=> o_PRE_RAMP_REF == 0)
    else $error("pre-ramp reference not zero after permit loss");

  a_run_latch_set: assert property (@(posedge I_CLOCK)
    disable iff (!I_RESETN)
    s_run_press ##1 (permit_s && !normal_off)[*3] |-> o_REF_ON)
    else $error("reference-on did not latch from run input");

  a_ref_on_hold: assert property (@(posedge I_CLOCK)
    disable iff (!I_RESETN)
    o_REF_ON && permit_s && !normal_off |=> o_REF_ON)
    else $error("reference-on dropped while permit held");

  a_ref_needs_permit: assert property (@(posedge I_CLOCK)
    disable iff (!I_RESETN) $rose(o_REF_ON) |-> $past(permit_s))
    else $error("reference-on rose without permit");

  a_inch_gated: assert property (@(posedge I_CLOCK)
    disable iff (!I_RESETN)
    normal_off |=> !o_INCH_REV && !o_INCH_FWD && !o_RUN_REV && !o_RUN_FWD)
    else $error("fixed command active with normal logic off");

  a_loop_trip_set: assert property (@(posedge I_CLOCK)
    disable iff (!I_RESETN)
    $rose(o_LOOP_OPEN_TRIP) |-> $past(cur_select && loop_offset
                                       && loop_low))
    else $error("loop trip without low offset loop current");

  a_loop_trip_hit: assert property (@(posedge I_CLOCK)
    disable iff (!I_RESETN)
    cur_select && loop_offset && loop_low |=> o_LOOP_OPEN_TRIP)
    else $error("loop trip missed at low current");

  a_stop_no_hold: assert property (@(posedge I_CLOCK)
    disable iff (!I_RESETN)
    !permit_s && !i_RAMP_HOLD |=> o_DRIVE_STOP ##1 $past(o_DRIVE_STOP))
    else $error("motor not stopped after permit loss");

  a_state_report: assert property (@(posedge I_CLOCK)
    disable iff (!I_RESETN)
    ##1 o_LOGIC_STATE == $past(logic_s) && o_START_PERMIT == $past(permit_s))
    else $error("input state report does not follow inputs");

  a_monitor_raw: assert property (@(posedge I_CLOCK)
    disable iff (!I_RESETN)
    invert_cd |=> o_MON_IN_C == $past(i_ANALOG_IN_C))
    else $error("monitor of input c altered by inversion");

  a_unity_scale: assert property (@(posedge I_CLOCK)
    disable iff (!I_RESETN)
    scale[0] == SCALE_DEFAULT && $stable(scale[0])
    |=> ##1 o_ANALOG_IN_A == $past(i_ANALOG_IN_A, 2))
    else $error("unity scaling changed input a");
endmodule

//--- verif/drive_field_model.sv
`timescale 1ns/10ps
// field side: encoder socket, permit switch and logic switches
module drive_field_model #(
  parameter int ENC_HALF = 2 // encoder half period, in clock cycles
) (
  input wire logic i_clk,
  output logic o_encoder,
  output logic o_permit,
  output logic [drive_input_pkg::NUM_LOGIC-1:0] o_logic
);
  logic spin_on = 1'b0; // encoder turning
  int ph = 0; // phase within a half period
  // switches open at power up
  initial begin
    o_encoder = 1'b0;
    o_permit = 1'b0;
    o_logic = '0;
  end
  // steady pulse train, rate kept under the encoder limit
  always @(posedge i_clk) begin
    ph <= (ph + 1) % ENC_HALF;
    if (spin_on && ph == ENC_HALF - 1) begin
      o_encoder <= #1 ~o_encoder;
    end
  end
  // operator switch positions
  task automatic set_sw(input logic p, input logic [4:0] l);
    o_permit = p;
    o_logic = l;
  endtask
  // start or stop the encoder shaft
  task automatic spin(input logic on);
    spin_on = on;
  endtask
endmodule

//--- verif/drive_input_scaling_logic_test.sv
`timescale 1ns/10ps
// bench: parameter port tasks and terminal stimulus
module drive_input_scaling_logic_test;
  import drive_input_pkg::*;
  logic clk, rstn, we, enc, perm, hold, tclr; // controls
  logic [ADDR_W-1:0] addr; // parameter index
  logic [DATA_W-1:0] wdata, rdata; // parameter data
  logic signed [VAL_W-1:0] in_b, in_c, sv, src_a; // analog stimulus
  logic signed [VAL_W-1:0] o_b, o_c, m_c, sref, pre, oa; // results
  logic [MA_W-1:0] cur; // loop current
  logic [NUM_LOGIC-1:0] lin, lst; // logic pins and states
  logic trip, pst, ifwd, ron, stp; // status
  logic signed [VAL_W-1:0] in_a, in_d, src_b, src_c; // more stimulus
  logic signed [VAL_W-1:0] o_a, o_d, m_d, ob, oc; // more results
  logic rfwd; // latched run forward
  logic [NUM_DEST-1:0] dst; // routed destinations
  int err_total = 0;
  int tests_run = 0;
  // shortened encoder gate keeps the run brief
  drive_input_scaling_logic #(.ENC_WINDOW(100)) DUT (.I_CLOCK(clk),
    .I_RESETN(rstn), .i_PARAM_WE(we), .i_PARAM_ADDR(addr),
    .i_PARAM_WDATA(wdata), .o_PARAM_RDATA(rdata),
    .i_ANALOG_IN_A(in_a), .i_ANALOG_IN_B(in_b), .i_ANALOG_IN_C(in_c),
    .i_ANALOG_IN_D(in_d), .i_SPEED_VOLT(sv), .i_SPEED_CURRENT(cur),
    .i_AOUT_SRC_A(src_a), .i_AOUT_SRC_B(src_b), .i_AOUT_SRC_C(src_c),
    .i_ENCODER_SOCKET(enc), .i_START_PERMIT_TERMINAL(perm),
    .i_LOGIC_IN(lin), .i_RAMP_HOLD(hold), .i_TRIP_CLEAR(tclr),
    .o_ANALOG_IN_A(o_a), .o_ANALOG_IN_B(o_b), .o_ANALOG_IN_C(o_c),
    .o_ANALOG_IN_D(o_d), .o_MON_IN_C(m_c), .o_MON_IN_D(m_d),
    .o_SPEED_REF_IN(sref), .o_PRE_RAMP_REF(pre), .o_ANALOG_OUT_A(oa),
    .o_ANALOG_OUT_B(ob), .o_ANALOG_OUT_C(oc), .o_LOOP_OPEN_TRIP(trip),
    .o_START_PERMIT(pst), .o_LOGIC_STATE(lst), .o_INCH_REV(),
    .o_INCH_FWD(ifwd), .o_RUN_REV(), .o_RUN_FWD(rfwd), .o_REF_ON(ron),
    .o_DRIVE_STOP(stp), .o_USER_DEST(dst));
  drive_field_model fld (.i_clk(clk), .o_encoder(enc), .o_permit(perm),
    .o_logic(lin));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // verdict and end of run
  task automatic test_done;
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // compare one value
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (e !== g) begin
      err_total++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // let n edges pass, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle write strobe, then an idle cycle
  task automatic wr(input logic [ADDR_W-1:0] a, input int d);
    addr = a;
    wdata = DATA_W'(d);
    we = 1'b1;
    cyc(1);
    we = 1'b0;
    cyc(1);
  endtask
  // read answers one edge after the index is presented
  task automatic rd(input logic [ADDR_W-1:0] a, input int e);
    addr = a;
    cyc(1);
    chk("param", 16'(e), rdata);
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end
  // main sequence
  initial begin
    {rstn, we, hold, tclr} = 4'h0;
    {addr, wdata, cur} = '0;
    {in_b, in_c, sv, src_a} = '0;
    {in_a, in_d, src_b, src_c} = '0;
    cyc(10);
    rstn = 1'b1;
    cyc(2);
    for (int i = 0; i < 8; i++) rd(ADDR_W'(i), 1000);
    rd(P_ENC_SCALE, 750000000 / (1024 * 1750));
    rd(P_LOOP_OFFSET, 1);
    rd(5'h1F, 0);
    wr(5'h01, 2047);
    rd(5'h01, 1999);
    in_b = -11'sd333;
    wr(5'h01, 1500);
    cyc(3);
    chk("in_b", -499, o_b);
    in_b = 11'sd800;
    wr(5'h01, 1999);
    cyc(3);
    chk("in_b", 1000, o_b);
    in_c = 11'sd200;
    src_a = 11'sd400;
    in_a = -11'sd5;
    in_d = 11'sd300;
    src_b = 11'sd123;
    src_c = -11'sd456;
    wr(P_INVERT_CD, 1);
    wr(ADDR_W'(CH_OUT_A), 250);
    cyc(3);
    chk("in_c", -200, o_c);
    chk("mon_c", 200, m_c);
    chk("out_a", 100, oa);
    chk("in_a", -5, o_a);
    chk("in_d", -300, o_d);
    chk("mon_d", 300, m_d);
    chk("out_b", 123, ob);
    chk("out_c", -456, oc);
    fld.set_sw(1'b1, 5'h08);
    sv = 11'sd700;
    wr(ADDR_W'(CH_SPEED), 500);
    cyc(4);
    chk("permit", 1, pst);
    chk("logic", 16'h08, lst);
    chk("sref", 700, sref);
    chk("pre", 350, pre);
    chk("run_fwd", 1, rfwd);
    fld.set_sw(1'b1, 5'h00);
    cyc(4);
    chk("ref_on", 1, ron);
    fld.set_sw(1'b0, 5'h00);
    cyc(4);
    chk("pre", 0, pre);
    chk("stop", 1, stp);
    hold = 1'b1;
    cyc(2);
    chk("stop", 0, stp);
    wr(P_NORMAL_OFF, 1);
    wr(P_LOGIC_ROUTE, 5 << (L_INCH_FWD * DEST_W));
    fld.set_sw(1'b1, 5'h02);
    cyc(4);
    chk("inch_fwd", 0, ifwd);
    chk("dest", 16'h20, dst);
    wr(P_SOFT_REF_ON, 1);
    chk("ref_on", 1, ron);
    cur = 9'd30;
    wr(P_CUR_SELECT, 1);
    cyc(3);
    chk("trip", 1, trip);
    cur = 9'd100;
    tclr = 1'b1;
    cyc(2);
    tclr = 1'b0;
    chk("sref", (100 - LOOP_OFFSET) * VAL_LIMIT / (LOOP_FULL - LOOP_OFFSET),
        sref);
    wr(P_LOOP_OFFSET, 0);
    cur = 9'd30;
    cyc(3);
    chk("trip", 0, trip);
    wr(P_REF_SOURCE, 1);
    fld.spin(1'b1);
    cyc(350);
    chk("sref", 25 * 418 / 1000, sref);
    test_done();
  end
endmodule
